// [rtl/nand_multiplane_erase_id_sequencer.sv]
// File: NAND command sequencer for multi-plane, erase, reset and ID flows
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
// How it works
// RULE_01: Re-program uses 8B setup for both planes
// RULE_02: Host gives first plane before second
// RULE_03: Cache-ready only when both caches free
// RULE_04: Array-ready when cell programming completes
// RULE_05: Previous fail combines both N-1 pages
// RULE_06: Fail reports either current page error
// RULE_07: Host ending with 15 polls array-ready
// RULE_08: Copy-back preceded by two plane reads; the code has no page read and accepts 85 without one
// RULE_09: Copy-back stays within same plane
// RULE_10: Erase: 60, three rows, D0 starts
// RULE_11: Erase busy accepts only status, reset
// RULE_12: Erase end on pin, cache-ready, fail
// RULE_13: Two-plane erase: 60 twice, no dummy
// RULE_14: Reset aborts, clears, status reads E0
// RULE_15: Reset busy time, reset re-accepted
// RULE_16: 90 plus 00 gives five ID bytes
// RULE_17: ID byte order maker, device, three info
// RULE_18: 90 plus 20 returns ONFI ASCII
// RULE_19: Unique ID then complement, sixteen copies
// RULE_20: Host resumes readout with 00 after status
// RULE_21: Parameter page repeats, status resumes
// RULE_22: Parameter page: signature then revision 02
// RULE_23: Both ready bits zero while busy
// RULE_24: Dummy confirm gives short dummy busy
module nand_multiplane_erase_id_sequencer
	import nand_seq_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h5A,  // Arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'hA5, // Arbitrary value
	parameter logic [7:0] ID3 = 8'h90,
	parameter logic [7:0] ID4 = 8'h95,
	parameter logic [7:0] ID5 = 8'h56,
	parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978,
	parameter int PROG_CYCLES = PROG_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int PARAM_LEN = 256
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic ready_busy_o         // Ready/busy pin, high = ready
);
	localparam int TW = 20;

	// All sequencer state in one struct
	typedef struct packed {
		seq_state_t st;
		out_mode_t om;
		logic [7:0] cmd;       // Setup code of the flow in progress
		logic [2:0] acnt;      // Address cycles seen
		logic second;          // Second plane address phase
		logic cache_flow;      // Program ends in cache mode
		logic last_cache;      // Array still busy after cache confirm
		stat_t stat;
		logic [9:0] ptr;       // Read-out byte position
		logic inj;             // Software fail injection
		logic ack;
		logic [31:0] rdat;
		logic rb;
	} seq_s_t;
	seq_s_t s_r;
	seq_s_t s_nxt;

	// Timer control
	logic tload;
	logic [TW-1:0] tcount;
	logic tbusy;

	busy_timer #(.W(TW)) u_timer (.clk_i(clk_i), .rst_i(rst_i),
		.load_i(tload), .count_i(tcount), .busy_o(tbusy));

	// Parameter page byte; rest of structure reads zero
	function automatic logic [7:0] param_byte(input logic [9:0] p);
		logic [7:0] i;
		i = p[7:0];
		case (i)
			8'h00: param_byte = 8'h4F; // RULE_22
			8'h01: param_byte = 8'h4E;
			8'h02: param_byte = 8'h46;
			8'h03: param_byte = 8'h49;
			8'h04: param_byte = 8'h02; // RULE_22
			default: param_byte = 8'h00;
		endcase
	endfunction

	// Unique ID byte: 16 id then 16 complement, repeating
	function automatic logic [7:0] uniq_byte(input logic [9:0] p);
		logic [7:0] b;
		b = UNIQUE_ID[8*(15-p[3:0]) +: 8];
		uniq_byte = p[4] ? ~b : b; // RULE_19
	endfunction

	function automatic logic [7:0] status_byte(input stat_t s);
		status_byte = {1'b1, s.cache_ready_bit, s.array_ready_bit,
			3'b000, s.previous_page_fail_bit, s.fail_bit};
	endfunction

	logic wr;
	logic rd;
	logic is_addr;
	logic [7:0] code;
	logic array_busy;
	// Writes act at the edge where the master sees ack high
	assign wr = cyc_i && stb_i && we_i && s_r.ack;
	assign rd = cyc_i && stb_i && !we_i && !s_r.ack;
	assign is_addr = dat_i[KIND_POS];
	assign code = dat_i[7:0];
	assign array_busy = (s_r.st == S_ERASE) || (s_r.st == S_PROG)
		|| (s_r.st == S_CACHE) || (s_r.st == S_RST) || s_r.last_cache;

	// Next state of the whole sequencer
	always_comb begin
		s_nxt = s_r;
		tload = 1'b0;
		tcount = '0;
		s_nxt.ack = cyc_i && stb_i && !s_r.ack;
		s_nxt.rdat = 32'h0000_0000;
		// Timed phases end
		if (!tbusy && !tload) begin
			case (s_r.st)
				S_DBSY: begin // RULE_24
					s_nxt.st = S_IDLE;
					s_nxt.stat.cache_ready_bit = 1'b1;
					s_nxt.stat.array_ready_bit = 1'b1;
				end
				S_CACHE: begin
					// Caches freed; array keeps programming
					s_nxt.st = S_IDLE;
					s_nxt.stat.cache_ready_bit = 1'b1; // RULE_03
					s_nxt.stat.previous_page_fail_bit = s_r.stat.fail_bit; // RULE_05
					s_nxt.last_cache = 1'b1;
					tload = 1'b1;
					tcount = TW'(PROG_CYCLES);
				end
				S_PROG, S_ERASE: begin
					s_nxt.st = S_IDLE;
					s_nxt.stat.cache_ready_bit = 1'b1; // RULE_12
					s_nxt.stat.array_ready_bit = 1'b1; // RULE_04
					s_nxt.stat.fail_bit = s_r.inj;     // RULE_06
				end
				S_RST: begin
					s_nxt.st = S_IDLE;
					s_nxt.stat = STAT_RESET[6:5] == 2'b11 ?
						4'b0011 : 4'b0000; // RULE_14
				end
				default: begin
					if (s_r.last_cache) begin
						s_nxt.last_cache = 1'b0;
						s_nxt.stat.array_ready_bit = 1'b1; // RULE_04
						s_nxt.stat.fail_bit = s_r.inj;     // RULE_06
					end
				end
			endcase
		end
		// Register writes
		if (wr && adr_i == CTRL_OFS && sel_i[0]) begin
			s_nxt.inj = dat_i[0];
		end
		if (wr && adr_i == CMD_OFS && sel_i[0] && sel_i[1]) begin
			if (!is_addr && code == C_RESET) begin
				// Abort anything, restart reset busy
				s_nxt.st = S_RST; // RULE_14 RULE_15
				s_nxt.cmd = 8'h00;
				s_nxt.last_cache = 1'b0;
				s_nxt.om = O_STATUS;
				s_nxt.stat = '0; // RULE_23
				tload = 1'b1;
				tcount = TW'(RST_CYC);
			end else if (!is_addr && code == C_STATUS) begin
				s_nxt.om = O_STATUS;
			end else if (s_r.st == S_ERASE || s_r.st == S_RST
					|| s_r.st == S_PROG || s_r.st == S_CACHE
					|| s_r.st == S_DBSY) begin // RULE_11
				// Ignored while busy; a timed end in this cycle still lands
			end else if (!is_addr) begin
				case (code)
					C_PROG, C_PROG2, C_REPROG, C_COPY: begin // RULE_01
						s_nxt.st = S_ADDR;
						s_nxt.cmd = code;
						s_nxt.acnt = '0;
						s_nxt.second = (s_r.st == S_DATA) || s_r.second;
					end
					C_ERASE: begin // RULE_10 RULE_13
						s_nxt.second = (s_r.st == S_DATA)
							&& (s_r.cmd == C_ERASE);
						s_nxt.st = S_ADDR;
						s_nxt.cmd = code;
						s_nxt.acnt = '0;
					end
					C_DUMMY: begin
						if (s_r.st == S_DATA && s_r.cmd != C_ERASE) begin
							s_nxt.st = S_DBSY; // RULE_24
							s_nxt.second = 1'b1;
							s_nxt.stat.cache_ready_bit = 1'b0;
							s_nxt.stat.array_ready_bit = 1'b0;
							tload = 1'b1;
							tcount = TW'(DBSY_CYC);
						end
					end
					C_CONF, C_CACHE: begin
						if (s_r.st == S_DATA && s_r.cmd != C_ERASE) begin
							s_nxt.st = (code == C_CACHE) ? S_CACHE : S_PROG;
							s_nxt.second = 1'b0;
							s_nxt.stat = '0; // RULE_23
							s_nxt.stat.previous_page_fail_bit =
								s_r.stat.previous_page_fail_bit;
							// Cache confirm keeps the last result for handover
							s_nxt.stat.fail_bit = (code == C_CACHE)
								&& s_r.stat.fail_bit; // RULE_05
							s_nxt.last_cache = 1'b0;
							tload = 1'b1;
							tcount = (code == C_CACHE) ? TW'(DBSY_CYC) :
								TW'(PROG_CYCLES);
						end
					end
					C_ERCONF: begin
						if (s_r.st == S_DATA && s_r.cmd == C_ERASE) begin
							s_nxt.st = S_ERASE; // RULE_10
							s_nxt.second = 1'b0;
							s_nxt.stat = '0;
							tload = 1'b1;
							tcount = TW'(ERASE_CYCLES);
						end
					end
					C_ID, C_UNIQ, C_PARAM: begin
						// Output waits for the address cycle
						s_nxt.st = (code == C_ID) ? S_ID :
							(code == C_UNIQ) ? S_UNIQ : S_PARAM;
						s_nxt.om = O_NONE;
					end
					C_READ: begin
						// Resume readout after status poll
						if (s_r.st == S_UNIQ) s_nxt.om = O_UNIQ; // RULE_20
						if (s_r.st == S_PARAM) s_nxt.om = O_PARAM; // RULE_21
					end
					default: s_nxt.st = S_IDLE;
				endcase
			end else begin
				// Address cycles
				case (s_r.st)
					S_ADDR: begin
						s_nxt.acnt = s_r.acnt + 3'd1;
						// Erase takes rows only, program column and row
						if (s_r.acnt == ((s_r.cmd == C_ERASE) ?
								3'(ROW_CYC - 1) : 3'(COL_ROW_CYC - 1))) begin
							s_nxt.st = S_DATA; // RULE_10
						end
					end
					S_ID, S_UNIQ, S_PARAM: begin
						// Readout restarts at byte zero
						s_nxt.ptr = '0;
						s_nxt.om = (s_r.st == S_UNIQ) ? O_UNIQ :
							(s_r.st == S_PARAM) ? O_PARAM :
							(code == A_ONFI) ? O_ONFI : O_ID; // RULE_16
					end
					default: s_nxt.st = s_r.st;
				endcase
			end
		end
		// Reads
		if (rd) begin
			case (adr_i)
				DATA_OFS: begin
					// Status polls leave the readout position alone
					if (s_r.om != O_STATUS) begin
						s_nxt.ptr = s_r.ptr + 10'd1; // RULE_20 RULE_21
					end
					case (s_r.om)
						O_STATUS: s_nxt.rdat[7:0] = status_byte(s_r.stat);
						O_ID: begin // RULE_17
							case (s_r.ptr[2:0])
								3'd0: s_nxt.rdat[7:0] = MAKER_CODE;
								3'd1: s_nxt.rdat[7:0] = DEVICE_CODE;
								3'd2: s_nxt.rdat[7:0] = ID3;
								3'd3: s_nxt.rdat[7:0] = ID4;
								3'd4: s_nxt.rdat[7:0] = ID5;
								default: s_nxt.rdat[7:0] = 8'h00;
							endcase
						end
						O_ONFI: s_nxt.rdat[7:0] = param_byte(s_r.ptr & 10'h003); // RULE_18
						O_UNIQ: s_nxt.rdat[7:0] = uniq_byte(s_r.ptr);
						O_PARAM: s_nxt.rdat[7:0] = param_byte(
							10'(s_r.ptr % 10'(PARAM_LEN))); // RULE_21
						default: s_nxt.rdat[7:0] = 8'h00;
					endcase
				end
				STAT_OFS: s_nxt.rdat = {24'h0, status_byte(s_r.stat)};
				CTRL_OFS: s_nxt.rdat = {31'h0, s_r.inj};
				default: s_nxt.rdat = 32'h0000_0000;
			endcase
		end
		s_nxt.rb = !(s_nxt.st == S_ERASE || s_nxt.st == S_PROG
			|| s_nxt.st == S_CACHE || s_nxt.st == S_RST
			|| s_nxt.st == S_DBSY); // RULE_12 RULE_15
	end

	// Register the struct
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0; // Zero is the idle state and status output
			s_r.stat <= 4'b0011;
			s_r.rb <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dat_o = s_r.rdat;
	assign ack_o = s_r.ack;
	assign ready_busy_o = s_r.rb;

	// Erase confirm drops ready/busy next cycle
	erase_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_r.st == S_DATA && s_r.cmd == C_ERASE && wr && adr_i == CMD_OFS
		&& !is_addr && code == C_ERCONF && sel_i[1:0] == 2'b11
		|=> !ready_busy_o) // RULE_10
		else $error("erase did not go busy");
	erase_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_r.st == S_ERASE && wr && !is_addr && code == C_ID
		|=> s_r.st == S_ERASE || s_r.st == S_IDLE) // RULE_11
		else $error("command accepted during erase");
	busy_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ready_busy_o |-> !s_r.stat.cache_ready_bit) // RULE_23
		else $error("ready bit high while busy");
	array_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_r.stat.array_ready_bit |-> !array_busy) // RULE_04
		else $error("array ready during array work");
	cache_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_r.st == S_CACHE |-> !s_r.stat.cache_ready_bit) // RULE_03
		else $error("cache ready too early");
	reset_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == CMD_OFS && !is_addr && code == C_RESET
		&& sel_i[1:0] == 2'b11 |=> s_r.st == S_RST && !ready_busy_o) // RULE_15
		else $error("reset not busy");
	reset_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_r.st == S_RST ##1 s_r.st == S_IDLE |-> s_r.stat == 4'b0011) // RULE_14
		else $error("status not E0 after reset");
	dummy_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(s_r.st == S_DBSY) |-> !ready_busy_o [*2]) // RULE_24
		else $error("dummy busy too short");
	ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held two cycles");
	erase_cov: cover property (@(posedge clk_i) s_r.st == S_ERASE);
	cache_cov: cover property (@(posedge clk_i) s_r.st == S_CACHE);
	reset_cov: cover property (@(posedge clk_i) s_r.st == S_RST);
	id_cov: cover property (@(posedge clk_i) s_r.om == O_ONFI && rd);
endmodule // nand_multiplane_erase_id_sequencer

// [rtl/nand_seq_pkg.sv]
// Package: constants, types and register layout of the command sequencer
package nand_seq_pkg;
	// Wishbone register word offsets (byte addresses)
	localparam logic [7:0] CMD_OFS = 8'h00;    // Command/address cycle port
	localparam logic [7:0] DATA_OFS = 8'h04;   // Read data port
	localparam logic [7:0] STAT_OFS = 8'h08;   // Status register
	localparam logic [7:0] CTRL_OFS = 8'h0C;   // Control: fail injection
	// Command port fields
	localparam int KIND_POS = 8;               // Bit 8: 1 = address cycle
	// Command codes
	localparam logic [7:0] C_PROG = 8'h80;
	localparam logic [7:0] C_PROG2 = 8'h81;
	localparam logic [7:0] C_REPROG = 8'h8B;
	localparam logic [7:0] C_COPY = 8'h85;
	localparam logic [7:0] C_DUMMY = 8'h11;
	localparam logic [7:0] C_CONF = 8'h10;
	localparam logic [7:0] C_CACHE = 8'h15;
	localparam logic [7:0] C_ERASE = 8'h60;
	localparam logic [7:0] C_ERCONF = 8'hD0;
	localparam logic [7:0] C_RESET = 8'hFF;
	localparam logic [7:0] C_ID = 8'h90;
	localparam logic [7:0] C_UNIQ = 8'hED;
	localparam logic [7:0] C_PARAM = 8'hEC;
	localparam logic [7:0] C_STATUS = 8'h70;
	localparam logic [7:0] C_READ = 8'h00;
	localparam logic [7:0] A_ID = 8'h00;
	localparam logic [7:0] A_ONFI = 8'h20;
	// Status values
	localparam logic [7:0] STAT_RESET = 8'hE0;
	localparam int ROW_CYC = 3;                // Erase row address cycles
	localparam int COL_ROW_CYC = 5;            // Program address cycles
	// Timing (ns) and derived cycle counts at 25 MHz
	localparam int CLK_NS = 40;
	localparam int DBSY_NS = 500;              // Dummy busy time
	localparam int RST_NS = 5000;              // Reset busy time
	localparam int PROG_NS = 300000;           // Page program time
	localparam int ERASE_NS = 3000000;         // Block erase time
	localparam int DBSY_CYC = DBSY_NS / CLK_NS;
	localparam int RST_CYC = RST_NS / CLK_NS;
	localparam int PROG_CYC = PROG_NS / CLK_NS;
	localparam int ERASE_CYC = ERASE_NS / CLK_NS;
	// Sequencer states
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_DATA, S_DBSY, S_PROG, S_CACHE,
		S_ERASE, S_RST, S_ID, S_UNIQ, S_PARAM
	} seq_state_t;
	// Output mode of the read data port
	typedef enum logic [2:0] {
		O_STATUS, O_ID, O_ONFI, O_UNIQ, O_PARAM, O_NONE
	} out_mode_t;
	// Status bits as seen by software
	typedef struct packed {
		logic fail_bit;
		logic previous_page_fail_bit;
		logic array_ready_bit;
		logic cache_ready_bit;
	} stat_t;
	// Wishbone request bundle
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [31:0] dat;
	} wb_req_t;
endpackage

// [rtl/busy_timer.sv]
// File: down-counting busy timer used for all array and reset delays
`timescale 1ns/1ps
module busy_timer
	import nand_seq_pkg::*;
#(
	parameter int W = 20
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic load_i,          // Load pulse, restarts count
	input wire logic [W-1:0] count_i, // Cycles to stay busy
	output logic busy_o               // High while counting
);
	// Whole state in one struct
	typedef struct packed {
		logic [W-1:0] cnt;
	} tmr_t;
	tmr_t s_r;
	tmr_t s_nxt;

	// Next count: load wins over decrement
	always_comb begin
		s_nxt = s_r;
		if (load_i) begin
			s_nxt.cnt = count_i;
		end else if (s_r.cnt != '0) begin
			s_nxt.cnt = s_r.cnt - W'(1);
		end
	end

	// Register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy_o = (s_r.cnt != '0);

	// Load of N cycles gives busy on the next edge
	load_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		load_i && count_i != '0 |=> busy_o)
		else $error("timer not busy after load");
endmodule // busy_timer

// [tb/nand_host_model.sv]
// Host controller model: Wishbone master issuing NAND cycles
`timescale 1ns/1ps
module nand_host_model
	import nand_seq_pkg::*;
(
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic [31:0] dat_i,
	input wire logic rb_i,
	output wb_req_t req_o,
	output logic [3:0] sel_o,
	output logic hang_o
);
	logic [31:0] rd_q; // Data of the last read
	logic dbsy_q; // Pin level just after a dummy confirm
	logic [3:0] sel_q; // Byte lanes of the next request
	// Idle bus and no hang at time zero
	initial begin
		req_o = '0;
		sel_o = 4'h0;
		sel_q = 4'hF;
		hang_o = 1'b0;
		dbsy_q = 1'b1;
	end
	// One classic cycle, held until ack is sampled high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req_o <= '{1'b1, 1'b1, w, a, d};
		sel_o <= sel_q;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && n < 50);
		if (ack_i !== 1'b1)
			hang_o <= 1'b1;
		rd_q = dat_i;
		req_o <= '0;
	endtask
	// Command cycle
	task automatic cmd(input logic [7:0] c);
		xfer(1'b1, CMD_OFS, {23'h0, 1'b0, c});
	endtask
	// Address bytes, lowest first
	task automatic adrs(input logic [39:0] v, input int n);
		for (int i = 0; i < n; i++)
			xfer(1'b1, CMD_OFS, {23'h0, 1'b1, v[8*i+:8]});
	endtask
	// One read of the data port
	task automatic rd(output logic [7:0] b);
		xfer(1'b0, DATA_OFS, 32'h0);
		b = rd_q[7:0];
	endtask
	// Bounded wait for the pin; first edge lets a fresh busy land
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (rb_i !== 1'b1 && n < 400);
		if (rb_i !== 1'b1)
			hang_o <= 1'b1;
	endtask
	// Two-plane load; second setup waits out the dummy busy
	task automatic two_plane(input logic [7:0] s1, s2, fin,
		input logic [39:0] v1, v2);
		cmd(s1);
		adrs(v1, COL_ROW_CYC);
		cmd(C_DUMMY);
		@(posedge clk_i);
		dbsy_q = rb_i;
		wait_ready();
		cmd(s2);
		adrs(v2, COL_ROW_CYC);
		cmd(fin);
	endtask
endmodule // nand_host_model

// [tb/nand_multiplane_erase_id_sequencer_bench.sv]
// Self-checking bench for the NAND command sequencer
`timescale 1ns/1ps
module nand_multiplane_erase_id_sequencer_bench;
	import nand_seq_pkg::*;
	localparam logic [7:0] MK = 8'h3C; // Arbitrary maker value
	localparam logic [7:0] DV = 8'hC3; // Arbitrary device value
	// Arbitrary identifier
	localparam logic [127:0] UQ = 128'h00112233445566778899AABBCCDDEEFF;
	logic clk_i, rst_i, ack_o, ready_busy_o, hang;
	logic [31:0] dat_o;
	wb_req_t req;
	int err_total, n_checks, seed, n;
	logic [7:0] s, f;
	logic [3:0] sel; // Byte lanes from the host
	logic [7:0] pg[0:259]; // Captured readout bytes
	logic [7:0] sig[4] = '{8'h4F, 8'h4E, 8'h46, 8'h49};
	logic [7:0] idb[5] = '{MK, DV, 8'h90, 8'h95, 8'h56};
	logic [7:0] st1[3] = '{C_PROG, C_REPROG, C_COPY};
	logic [7:0] st2[3] = '{C_PROG2, C_REPROG, C_COPY};
	// Short array times keep the run brief
	nand_multiplane_erase_id_sequencer #(.MAKER_CODE(MK), .DEVICE_CODE(DV),
		.ID3(8'h90), .ID4(8'h95), .ID5(8'h56), .UNIQUE_ID(UQ),
		.PROG_CYCLES(40), .ERASE_CYCLES(60)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc), .stb_i(req.stb),
		.we_i(req.we), .adr_i(req.adr), .sel_i(sel), .dat_i(req.dat),
		.dat_o(dat_o), .ack_o(ack_o), .ready_busy_o(ready_busy_o));
	nand_host_model i_host (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o),
		.rb_i(ready_busy_o), .req_o(req), .sel_o(sel), .hang_o(hang));
	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Compare and count
	task automatic chk(input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (err_total == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// A wait that ran out ends the run
	always @(posedge hang) begin
		err_total++;
		give_verdict();
	end
	task automatic status(output logic [7:0] v);
		i_host.cmd(C_STATUS);
		i_host.rd(v);
	endtask
	initial begin
		seed = 32'h3A6A;
		err_total = 0;
		n_checks = 0;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		status(s);
		chk(s, STAT_RESET);
		i_host.xfer(1'b0, STAT_OFS, 32'h0);
		chk(i_host.rd_q, {24'h0, STAT_RESET});
		// Command with a missing byte lane must be dropped
		i_host.sel_q = 4'h1;
		i_host.cmd(C_ID);
		i_host.sel_q = 4'hF;
		i_host.rd(s);
		chk(s, STAT_RESET);
		i_host.xfer(1'b0, 8'h40, 32'h0); // Unmapped place reads zero
		chk(i_host.rd_q, 32'h0);
		// Identification bytes, then the signature
		i_host.cmd(C_ID);
		i_host.adrs(A_ID, 1);
		for (int i = 0; i < 5; i++) begin
			i_host.rd(s);
			chk(s, idb[i]);
		end
		i_host.cmd(C_ID);
		i_host.adrs(A_ONFI, 1);
		for (int i = 0; i < 4; i++) begin
			i_host.rd(s);
			chk(s, sig[i]);
		end
		// Parameter page past its first copy, then poll and resume
		i_host.cmd(C_PARAM);
		i_host.adrs(8'h00, 1);
		for (int i = 0; i < 260; i++)
			i_host.rd(pg[i]);
		for (int i = 0; i < 4; i++)
			chk({pg[i], pg[256+i]}, {sig[i], sig[i]});
		chk({pg[5], pg[4]}, 16'h0002);
		status(s);
		i_host.cmd(C_READ);
		i_host.rd(s);
		chk(s, pg[4]);
		// Identifier with complement, second copy
		i_host.cmd(C_UNIQ);
		i_host.adrs(8'h00, 1);
		for (int i = 0; i < 48; i++)
			i_host.rd(pg[i]);
		for (int i = 0; i < 16; i++) begin
			chk(pg[i] ^ pg[i+16], 8'hFF);
			chk(pg[i+32], pg[i]);
		end
		// Poll status mid-readout, then resume with the read code
		status(s);
		i_host.cmd(C_READ);
		i_host.rd(s);
		chk(s, pg[16]);
		// Single erase, two-plane erase, erase cut by two resets
		for (int k = 0; k < 3; k++) begin
			f = 8'($random(seed));
			i_host.xfer(1'b1, CTRL_OFS, {31'h0, f[0]});
			i_host.xfer(1'b0, CTRL_OFS, 32'h0);
			chk(i_host.rd_q, {31'h0, f[0]});
			i_host.cmd(C_ERASE);
			i_host.adrs({8'h00, $random(seed)}, ROW_CYC);
			if (k == 1) begin
				@(posedge clk_i);
				chk(ready_busy_o, 1'b1);
				i_host.cmd(C_ERASE);
				i_host.adrs({8'h00, $random(seed)}, ROW_CYC);
			end
			i_host.cmd(C_ERCONF);
			@(posedge clk_i);
			chk(ready_busy_o, 1'b0);
			status(s);
			chk(s, 8'h80);
			i_host.cmd(C_ID); // Must be ignored while erasing
			i_host.rd(s);
			chk(s, 8'h80);
			if (k == 2) begin
				i_host.cmd(C_RESET);
				i_host.cmd(C_RESET);
				@(posedge clk_i);
				chk(ready_busy_o, 1'b0);
				f = 8'h00;
			end
			i_host.wait_ready();
			status(s);
			chk(s, {6'h38, 1'b0, f[0]});
		end
		// Two-plane program, re-program and copy-back
		for (int k = 0; k < 3; k++) begin
			f = 8'($random(seed));
			i_host.xfer(1'b1, CTRL_OFS, {31'h0, f[0]});
			i_host.two_plane(st1[k], st2[k], C_CONF,
				{8'h00, $random(seed)}, {8'h00, $random(seed)});
			chk(i_host.dbsy_q, 1'b0);
			@(posedge clk_i);
			chk(ready_busy_o, 1'b0);
			i_host.wait_ready();
			status(s);
			chk(s, {6'h38, 1'b0, f[0]});
		end
		// Cache program with a failing page
		i_host.xfer(1'b1, CTRL_OFS, 32'h1);
		i_host.two_plane(C_PROG, C_PROG2, C_CACHE,
			{8'h00, $random(seed)}, {8'h00, $random(seed)});
		i_host.wait_ready();
		status(s);
		chk(s[6:5], 2'b10);
		n = 0;
		do begin
			i_host.rd(s);
			n++;
		end while (s[5] !== 1'b1 && n < 100);
		chk(s, {6'h38, f[0], 1'b1});
		give_verdict();
	end
endmodule // nand_multiplane_erase_id_sequencer_bench
